/* File: logic/tsee_map.svh */
/*
 * Fixed numbers of the sensor-plus-memory slave: bus type fields,
 * sensor pointer slots, configuration bit positions, timing figures.
 * Assumes inclusion by the top module only.
 */
`ifndef TSEE_MAP_SVH
`define TSEE_MAP_SVH
// Device type fields of the slave address
`define TSEE_TYPE_SENS 4'h3
`define TSEE_TYPE_MEM 4'hA
`define TSEE_TYPE_PROT 4'h6
// Protection sub-addresses
`define TSEE_WP_SET 3'h1
`define TSEE_WP_CLR 3'h3
// Sensor register pointer slots
`define TSEE_P_CAP 4'h0
`define TSEE_P_CFG 4'h1
`define TSEE_P_UP 4'h2
`define TSEE_P_LO 4'h3
`define TSEE_P_CRIT 4'h4
`define TSEE_P_TEMP 4'h5
`define TSEE_CAP_RST 16'h001F
// Configuration bit positions
`define TSEE_CFG_SHDN 0
`define TSEE_CFG_INT 1
`define TSEE_CFG_CRIT 2
`define TSEE_CFG_STAT 4
`define TSEE_CFG_CLR 5
`define TSEE_CFG_HYST 8
// Hysteresis in 0.0625 C steps: 1.5, 3, 6 C
`define TSEE_HYST_1 16'h0018
`define TSEE_HYST_2 16'h0030
`define TSEE_HYST_3 16'h0060
`define TSEE_RD_IDLE 8'hFF
// Timing: clock in kHz, times in ms
`define TSEE_CLK_KHZ 125000
`define TSEE_WR_MS 5
`define TSEE_CONV_MS 100
`define TSEE_CONV_MAX_MS 125
`endif

/* File: logic/tsee_pkg.sv */
/*
 * Types of the sensor-plus-memory slave.
 * Assumes tsee_map.svh beside it.
 */
`default_nettype none
package tsee_pkg;
    // Bus slave states
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX,
        ST_TACK} tsee_st_e;
    // Addressed function
    typedef enum logic [1:0] {TG_SENS, TG_EE, TG_WP} tsee_tgt_e;
    // Sensor configuration
    typedef struct packed {
        logic [1:0] hyst;   // Hysteresis select
        logic crit_only;    // Alert on critical only
        logic int_mode;     // Interrupt behaviour
        logic shdn;         // Sensor shut down
    } tsee_cfg_s;
endpackage
`default_nettype wire

/* File: logic/tsee_top.sv */
/*
 * Two-wire bus slave: thermal sensor registers, 256 x 8 memory with
 * page buffer, lower-half write protection and open-drain alert.
 * Assumes bus pins and address pins arrive asynchronously, converter
 * result comes from logic on mclk, pins have outside pull resistors.
 */
`include "tsee_map.svh"
`default_nettype none
module tsee_top
    import tsee_pkg::*;
#(
    parameter int WR_CYC = `TSEE_WR_MS * `TSEE_CLK_KHZ,   // Write cycle
    parameter int CONV_CYC = `TSEE_CONV_MS * `TSEE_CLK_KHZ // Refresh
)(
    input wire logic mclk,             // 125 MHz clock
    input wire logic rst_n,            // Async reset, low
    input wire logic scl_i,            // Bus clock pin
    input wire logic sda_i,            // Bus data pin level
    output logic sda_o,                // Data drive level
    output logic sda_oe,               // Data pulled low
    input wire logic addr_select_bit0, // Select pin 0
    input wire logic addr_select_bit1, // Select pin 1
    input wire logic addr_select_bit2, // Select pin 2
    input wire logic [11:0] temp_code_i, // Converter result
    output logic event_o,              // Alert drive level
    output logic event_oe,             // Alert pulled low
    output logic ee_busy               // Write cycle running
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] scl_q, sda_q; // Two sync stages plus edge stage
    logic [2:0] asel_q1, asel_q2; // Select pin sync
    // Sample pins, first stage read only by second
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            asel_q1 <= 3'h0;
            asel_q2 <= 3'h0;
        end
        else
        begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
            asel_q1 <= {addr_select_bit2, addr_select_bit1,
                addr_select_bit0};
            asel_q2 <= asel_q1;
        end
    end
    // Bus events
    wire scl_rise = scl_q[1] & ~scl_q[2];
    wire scl_fall = ~scl_q[1] & scl_q[2];
    wire bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    wire bus_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

    // ************************************************************
    // State
    // ************************************************************
    tsee_st_e st_r;            // Slave state
    tsee_tgt_e tgt_r;          // Addressed function
    tsee_cfg_s cfg_r;          // Sensor configuration
    logic [3:0] bit_r;         // Bit counter
    logic [7:0] sh_r;          // Shift register
    logic rw_r, ack_r, ph_r;   // Read flag, ack, ack phase
    logic mack_r, rd_lo_r;     // Master ack, low byte next
    logic [1:0] bn_r;          // Write byte index
    logic [3:0] ptr_r;         // Sensor pointer
    logic [7:0] hi_r;          // Sensor data high byte
    logic [2:0] sub_r;         // Protection sub-address
    logic [7:0] ee_addr_r;     // Memory address counter
    logic [7:0] mem [256];     // Memory array
    logic [7:0] pbuf [16];     // Page buffer
    logic [15:0] pval_r;       // Page buffer valid
    logic [3:0] page_r;        // Page of buffered bytes
    logic busy_r, wp_r, pwp_r; // Write cycle, protection
    logic [23:0] wr_cnt_r, cv_cnt_r; // Timers
    logic [11:0] temp_r;       // Latched result
    logic [15:0] up_r, lo_r, crit_r; // Limits
    logic crit_st_r, up_st_r, lo_st_r, cond_q_r, evt_r; // Alert

    // ************************************************************
    // Decoding
    // ************************************************************
    wire [7:0] rx_byte = {sh_r[6:0], sda_q[1]};
    wire rx_done = st_r == ST_RX && scl_rise && bit_r == 4'h7;
    wire ad_done = st_r == ST_ADDR && scl_rise && bit_r == 4'h7;
    wire sel_ok = rx_byte[3:1] == asel_q2;
    wire a_sens = rx_byte[7:4] == `TSEE_TYPE_SENS && sel_ok;
    wire a_ee = rx_byte[7:4] == `TSEE_TYPE_MEM && sel_ok && !busy_r;
    wire a_wp = rx_byte[7:4] == `TSEE_TYPE_PROT && !busy_r && !pwp_r;
    wire lo_prot = !ee_addr_r[7] && (wp_r || pwp_r);
    wire ee_store = rx_done && tgt_r == TG_EE && bn_r != 2'h0;
    wire sens_wr = rx_done && tgt_r == TG_SENS && bn_r == 2'h2;
    wire [15:0] wr_word = {hi_r, rx_byte};
    wire ld = st_r == ST_ACK && scl_fall && ph_r && rw_r && ack_r ||
        st_r == ST_TACK && scl_fall && mack_r;
    wire wr_end = busy_r && wr_cnt_r == 24'(WR_CYC - 1);
    wire conv_tick = !cfg_r.shdn && cv_cnt_r == 24'(CONV_CYC - 1);
    wire evt_clr = sens_wr && ptr_r == `TSEE_P_CFG &&
        wr_word[`TSEE_CFG_CLR];
    wire [15:0] temp_w = {{4{temp_r[11]}}, temp_r};
    // Hysteresis lands in bits 9:8, status in bit 4
    wire [15:0] cfg_w = 16'({cfg_r.hyst, 3'h0, evt_r, 1'b0,
        cfg_r.crit_only, cfg_r.int_mode, cfg_r.shdn}) <<
        `TSEE_CFG_SHDN;
    wire [15:0] sens_word =
        ptr_r == `TSEE_P_CAP ? `TSEE_CAP_RST :
        ptr_r == `TSEE_P_CFG ? cfg_w :
        ptr_r == `TSEE_P_UP ? up_r :
        ptr_r == `TSEE_P_LO ? lo_r :
        ptr_r == `TSEE_P_CRIT ? crit_r :
        ptr_r == `TSEE_P_TEMP ? temp_w : 16'h0000;
    wire [7:0] tx_byte = tgt_r == TG_EE ? mem[ee_addr_r] :
        tgt_r == TG_WP ? `TSEE_RD_IDLE :
        rd_lo_r ? sens_word[7:0] : sens_word[15:8];
    wire [15:0] hyst_w = cfg_r.hyst == 2'h1 ? `TSEE_HYST_1 :
        cfg_r.hyst == 2'h2 ? `TSEE_HYST_2 :
        cfg_r.hyst == 2'h3 ? `TSEE_HYST_3 : 16'h0000;
    // Hysteresis release points
    wire [15:0] crit_rel = 16'(crit_r - hyst_w);
    wire [15:0] up_rel = 16'(up_r - hyst_w);
    wire [15:0] lo_rel = 16'(lo_r + hyst_w);
    wire cond_w = cfg_r.crit_only ? crit_st_r :
        crit_st_r | up_st_r | lo_st_r;
    assign sda_o = 1'b0;
    assign event_o = 1'b0;
    assign event_oe = evt_r;
    assign ee_busy = busy_r;

    // ************************************************************
    // Bus slave state machine
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_IDLE;
            tgt_r <= TG_SENS;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            {rw_r, ack_r, ph_r, mack_r, sda_oe} <= 5'h00;
        end
        else if (bus_stop)
        begin
            st_r <= ST_IDLE;
            sda_oe <= 1'b0;
        end
        else if (bus_start)
        begin
            st_r <= ST_ADDR;
            bit_r <= 4'h0;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (st_r)
                ST_ADDR, ST_RX:
                    // Shift in one byte, ack on next fall
                    if (scl_rise)
                    begin
                        sh_r <= rx_byte;
                        bit_r <= 4'(bit_r + 4'h1);
                        if (bit_r == 4'h7)
                        begin
                            st_r <= ST_ACK;
                            ph_r <= 1'b0;
                        end
                        if (ad_done)
                        begin
                            rw_r <= rx_byte[0];
                            ack_r <= a_sens | a_ee | a_wp;
                            tgt_r <= a_ee ? TG_EE : a_wp ? TG_WP : TG_SENS;
                        end
                        else if (bit_r == 4'h7)
                            ack_r <= !(tgt_r == TG_EE && bn_r != 2'h0 &&
                                lo_prot);
                    end
                ST_ACK:
                    // Two falls: drive ack, then release or send
                    if (scl_fall)
                    begin
                        ph_r <= 1'b1;
                        bit_r <= 4'h0;
                        sda_oe <= !ph_r && ack_r;
                        if (ph_r && !ack_r)
                            st_r <= ST_IDLE;
                        else if (ph_r && rw_r)
                        begin
                            st_r <= ST_TX;
                            sh_r <= {tx_byte[6:0], 1'b0};
                            sda_oe <= !tx_byte[7];
                            bit_r <= 4'h1;
                        end
                        else if (ph_r)
                            st_r <= ST_RX;
                    end
                ST_TX:
                    // Drive next bit on each fall
                    if (scl_fall)
                    begin
                        if (bit_r == 4'h8)
                        begin
                            st_r <= ST_TACK;
                            sda_oe <= 1'b0;
                        end
                        else
                        begin
                            sda_oe <= !sh_r[7];
                            sh_r <= {sh_r[6:0], 1'b0};
                            bit_r <= 4'(bit_r + 4'h1);
                        end
                    end
                ST_TACK:
                    // Master ack continues, no ack ends read
                    if (scl_rise)
                        mack_r <= !sda_q[1];
                    else if (scl_fall && !mack_r)
                        st_r <= ST_IDLE;
                    else if (scl_fall)
                    begin
                        st_r <= ST_TX;
                        sh_r <= {tx_byte[6:0], 1'b0};
                        sda_oe <= !tx_byte[7];
                        bit_r <= 4'h1;
                    end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Write bytes and sensor registers
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bn_r <= 2'h0;
            ptr_r <= `TSEE_P_CAP;
            hi_r <= 8'h00;
            sub_r <= 3'h0;
            rd_lo_r <= 1'b0;
            cfg_r <= '0;
            {up_r, lo_r, crit_r} <= '0;
        end
        else
        begin
            if (ad_done)
            begin
                bn_r <= 2'h0;
                sub_r <= rx_byte[3:1];
                rd_lo_r <= 1'b0;
            end
            else if (rx_done && bn_r != 2'h3)
                bn_r <= 2'(bn_r + 2'h1);
            if (rx_done && tgt_r == TG_SENS && bn_r == 2'h0)
                ptr_r <= rx_byte[3:0];
            if (rx_done && tgt_r == TG_SENS && bn_r == 2'h1)
                hi_r <= rx_byte;
            if (ld && tgt_r == TG_SENS)
                rd_lo_r <= !rd_lo_r;
            // Writable sensor registers
            if (sens_wr && ptr_r == `TSEE_P_CFG)
                cfg_r <= {wr_word[`TSEE_CFG_HYST+1:`TSEE_CFG_HYST],
                    wr_word[`TSEE_CFG_CRIT], wr_word[`TSEE_CFG_INT],
                    wr_word[`TSEE_CFG_SHDN]};
            if (sens_wr && ptr_r == `TSEE_P_UP)
                up_r <= wr_word;
            if (sens_wr && ptr_r == `TSEE_P_LO)
                lo_r <= wr_word;
            if (sens_wr && ptr_r == `TSEE_P_CRIT)
                crit_r <= wr_word;
        end
    end

    // ************************************************************
    // Memory address, page buffer, write cycle, protection
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ee_addr_r <= 8'h00;
            pval_r <= 16'h0000;
            page_r <= 4'h0;
            {busy_r, wp_r, pwp_r} <= 3'h0;
            wr_cnt_r <= 24'h000000;
        end
        else
        begin
            if (rx_done && tgt_r == TG_EE && bn_r == 2'h0)
                ee_addr_r <= rx_byte;
            else if (ee_store && !lo_prot)
            begin
                // Wrap inside the 16-byte page
                pbuf[ee_addr_r[3:0]] <= rx_byte;
                pval_r[ee_addr_r[3:0]] <= 1'b1;
                page_r <= ee_addr_r[7:4];
                ee_addr_r[3:0] <= 4'(ee_addr_r[3:0] + 4'h1);
            end
            else if (ld && tgt_r == TG_EE)
                ee_addr_r <= 8'(ee_addr_r + 8'h01);
            // Start programming at stop
            if (bus_stop && tgt_r == TG_EE && !busy_r && |pval_r)
            begin
                busy_r <= 1'b1;
                wr_cnt_r <= 24'h000000;
            end
            else if (wr_end)
            begin
                busy_r <= 1'b0;
                pval_r <= 16'h0000;
                for (int i = 0; i < 16; i++)
                    if (pval_r[i])
                        mem[{page_r, 4'(i)}] <= pbuf[i];
            end
            else if (busy_r)
                wr_cnt_r <= 24'(wr_cnt_r + 24'h000001);
            // Protection commands take effect at stop
            if (bus_stop && tgt_r == TG_WP && !rw_r && ack_r)
            begin
                if (sub_r == `TSEE_WP_SET)
                    wp_r <= 1'b1;
                else if (sub_r == `TSEE_WP_CLR)
                    wp_r <= 1'b0;
                else if (sub_r == asel_q2)
                    pwp_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Conversion timer and alert
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cv_cnt_r <= 24'h000000;
            temp_r <= 12'h000;
            {crit_st_r, up_st_r, lo_st_r, cond_q_r, evt_r} <= 5'h00;
        end
        else
        begin
            // Refresh period, halted in shutdown
            if (cfg_r.shdn || conv_tick)
                cv_cnt_r <= 24'h000000;
            else
                cv_cnt_r <= 24'(cv_cnt_r + 24'h000001);
            if (conv_tick)
                temp_r <= temp_code_i;
            // Limit states with hysteresis
            if ($signed(temp_w) > $signed(crit_r))
                crit_st_r <= 1'b1;
            else if ($signed(temp_w) <= $signed(crit_rel))
                crit_st_r <= 1'b0;
            if ($signed(temp_w) > $signed(up_r))
                up_st_r <= 1'b1;
            else if ($signed(temp_w) <= $signed(up_rel))
                up_st_r <= 1'b0;
            if ($signed(temp_w) < $signed(lo_r))
                lo_st_r <= 1'b1;
            else if ($signed(temp_w) >= $signed(lo_rel))
                lo_st_r <= 1'b0;
            cond_q_r <= cond_w;
            // Comparator follows, interrupt latches until cleared
            if (!cfg_r.int_mode)
                evt_r <= cond_w;
            else if (cond_w && !cond_q_r)
                evt_r <= 1'b1;
            else if (evt_clr)
                evt_r <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_wr_time;
        @(posedge mclk) disable iff (!rst_n)
        busy_r |-> wr_cnt_r < 24'(WR_CYC);
    endproperty
    a_wr_time: assert property (p_wr_time)
        else $error("write cycle overran");
    property p_upper_ok;
        @(posedge mclk) disable iff (!rst_n)
        ee_store && ee_addr_r[7] |=> ack_r;
    endproperty
    a_upper_ok: assert property (p_upper_ok)
        else $error("upper half write refused");
    property p_lower_prot;
        @(posedge mclk) disable iff (!rst_n)
        ee_store && !ee_addr_r[7] && (wp_r || pwp_r) |=> !ack_r ##0
            $stable(pval_r);
    endproperty
    a_lower_prot: assert property (p_lower_prot)
        else $error("protected byte accepted");
    property p_rd_inc;
        @(posedge mclk) disable iff (!rst_n)
        ld && tgt_r == TG_EE |=> ee_addr_r == 8'($past(ee_addr_r) + 1);
    endproperty
    a_rd_inc: assert property (p_rd_inc)
        else $error("address did not advance");
    property p_page_wrap;
        @(posedge mclk) disable iff (!rst_n)
        ee_store && !lo_prot |=> ee_addr_r[7:4] == $past(ee_addr_r[7:4]);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page write left its page");
    property p_temp_hold;
        @(posedge mclk) disable iff (!rst_n)
        !conv_tick |=> $stable(temp_r);
    endproperty
    a_temp_hold: assert property (p_temp_hold)
        else $error("result changed between conversions");
    property p_conv_time;
        @(posedge mclk) disable iff (!rst_n)
        cv_cnt_r < 24'(`TSEE_CONV_MAX_MS * `TSEE_CLK_KHZ);
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion overran");
    property p_comp;
        @(posedge mclk) disable iff (!rst_n)
        !cfg_r.int_mode && !$past(cfg_r.int_mode) |-> event_oe ==
            $past(cond_w);
    endproperty
    a_comp: assert property (p_comp)
        else $error("comparator alert wrong");
    property p_crit_only;
        @(posedge mclk) disable iff (!rst_n)
        cfg_r.crit_only && !crit_st_r && !cfg_r.int_mode |=> !event_oe;
    endproperty
    a_crit_only: assert property (p_crit_only)
        else $error("alert outside critical-only");
    property p_addr;
        @(posedge mclk) disable iff (!rst_n)
        ad_done && rx_byte[7:4] != `TSEE_TYPE_SENS &&
            rx_byte[7:4] != `TSEE_TYPE_MEM &&
            rx_byte[7:4] != `TSEE_TYPE_PROT |=> !ack_r;
    endproperty
    a_addr: assert property (p_addr)
        else $error("foreign address acknowledged");
endmodule
`default_nettype wire

/* File: verif/tsee_master.sv */
/*
 * Two-wire bus master model: drives the bus clock, pulls data low.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`default_nettype none
module tsee_master
(
    input wire logic clk,    // Bench clock
    input wire logic sda,    // Resolved data wire
    output logic scl,        // Bus clock
    output logic sda_low     // High pulls data low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial scl = 1'b1;
    initial sda_low = 1'b0;
    // Quarter bit, 40 ns, just after an edge
    task automatic q();
        repeat (5) @(posedge clk);
        #1;
    endtask
    // One bit; data changes only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    // Start or repeated start
    task automatic start();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask
    // Byte out, MSB first, returns the slave's ack
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Byte in; last byte answered with no ack
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

/* File: verif/tsee_top_tb.sv */
/*
 * Self-checking bench of the sensor-plus-memory slave.
 * Assumes tsee_master as the bus master and short count parameters.
 */
`default_nettype none
module tsee_top_tb;
    import tsee_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CV = 40;  // Short conversion period
    localparam int WR = 400; // Short write cycle, outlasts one address
    logic mclk = 0, rst_n, scl, sda_low, sda_o, sda_oe, event_o, event_oe;
    logic ee_busy, ok;
    logic [2:0] sel;         // Select pins
    logic [11:0] temp_code_i;
    logic [15:0] v;
    wire sda = !(sda_oe | sda_low);  // Open-drain wire with pull-up
    int n_fail = 0, total_checks = 0;
    always #4 mclk = ~mclk;
    tsee_master m (.clk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
    tsee_top #(.WR_CYC(WR), .CONV_CYC(CV)) dut (.mclk(mclk),
        .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_bit0(sel[0]),
        .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]),
        .temp_code_i(temp_code_i), .event_o(event_o),
        .event_oe(event_oe), .ee_busy(ee_busy));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Address only; returns ack
    task automatic probe(input logic [7:0] a, output logic ak);
        m.start();
        m.wr(a, ak);
        m.stop();
    endtask
    task automatic sens_wr(input logic [3:0] p, input logic [15:0] d);
        logic [3:0] ak;
        m.start();
        m.wr({4'h3, sel, 1'b0}, ak[3]);
        m.wr({4'h0, p}, ak[2]);
        m.wr(d[15:8], ak[1]);
        m.wr(d[7:0], ak[0]);
        m.stop();
        chk(ak, 4'hF);
    endtask
    task automatic sens_rd(input logic [3:0] p, output logic [15:0] d);
        logic [2:0] ak;
        m.start();
        m.wr({4'h3, sel, 1'b0}, ak[2]);
        m.wr({4'h0, p}, ak[1]);
        m.start();
        m.wr({4'h3, sel, 1'b1}, ak[0]);
        m.rd(1'b0, d[15:8]);
        m.rd(1'b1, d[7:0]);
        m.stop();
        chk(ak, 3'h7);
    endtask
    // Writes n bytes d, d+1, ...; ok when all acked
    task automatic ee_wr(input logic [7:0] a, d, input int n,
        output logic ok);
        logic ak;
        m.start();
        m.wr({4'hA, sel, 1'b0}, ok);
        m.wr(a, ak);
        ok &= ak;
        for (int i = 0; i < n; i++)
        begin
            m.wr(d + 8'(i), ak);
            ok &= ak;
        end
        m.stop();
    endtask
    // Sequential read expecting e, e+1, ...
    task automatic ee_rd(input logic [7:0] a, e, input int n);
        logic [7:0] b;
        logic ak;
        m.start();
        m.wr({4'hA, sel, 1'b0}, ak);
        m.wr(a, ak);
        m.start();
        m.wr({4'hA, sel, 1'b1}, ak);
        for (int i = 0; i < n; i++)
        begin
            m.rd(i == n - 1, b);
            chk(b, e + 8'(i));
        end
        m.stop();
    endtask
    // Self-timed cycle ends within bound
    task automatic idle();
        for (int i = 0; i < WR + 20 && ee_busy !== 1'b0; i++)
            @(posedge mclk);
        #1;
        chk(ee_busy, 0);
    endtask
    task automatic temp(input logic [11:0] t, input logic exp);
        temp_code_i = t;
        repeat (CV * 2 + 5) @(posedge mclk);
        #1;
        chk(event_oe, exp);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #600us;
        n_fail++;
        results();
    end
    initial
    begin
        rst_n = 0;
        temp_code_i = 0;
        sel = 3'h5;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1;
        repeat (4) @(posedge mclk);
        #1;
        chk({sda_o, event_o, sda_oe, event_oe, ee_busy}, 5'h00);
        sens_rd(4'h0, v);
        chk(v, 16'h001F);
        probe({4'h5, sel, 1'b0}, ok);
        chk(ok, 0);
        probe({4'h3, 3'h0, 1'b0}, ok);
        chk(ok, 0);
        ee_wr(8'h8E, 8'h40, 3, ok);
        chk({ok, ee_busy}, 2'h3);
        ee_wr(8'h20, 8'h00, 0, ok);
        chk(ok, 0);
        idle();
        ee_rd(8'h8E, 8'h40, 2);
        ee_rd(8'h80, 8'h42, 1);
        probe({4'h6, 3'h1, 1'b0}, ok);
        chk(ok, 1);
        ee_wr(8'h10, 8'h55, 1, ok);
        chk(ok, 0);
        idle();
        ee_wr(8'h90, 8'h66, 1, ok);
        chk(ok, 1);
        idle();
        probe({4'h6, 3'h3, 1'b0}, ok);
        ee_wr(8'h10, 8'h55, 1, ok);
        chk(ok, 1);
        idle();
        ee_rd(8'h10, 8'h55, 1);
        sens_wr(4'h2, 16'h0200);
        sens_wr(4'h4, 16'h0280);
        temp(12'h190, 0);
        sens_rd(4'h5, v);
        chk(v, 16'h0190);
        temp(12'h210, 1);
        sens_wr(4'h1, 16'h0004);
        temp(12'h210, 0);
        temp(12'h290, 1);
        sens_wr(4'h1, 16'h0100);
        temp(12'h1F0, 1);
        temp(12'h1E0, 0);
        sens_rd(4'h1, v);
        chk(v, 16'h0100);
        sens_wr(4'h1, 16'h0002);
        temp(12'h210, 1);
        temp(12'h100, 1);
        sens_wr(4'h1, 16'h0022);
        chk(event_oe, 0);
        sens_wr(4'h1, 16'h0001);
        temp(12'h0C0, 0);
        sens_rd(4'h5, v);
        chk(v, 16'h0100);
        results();
    end
endmodule
`default_nettype wire
